// ### hw/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter int W = 2, // number of pins
    parameter logic [W-1:0] RST_VAL = '0 // level assumed in reset
) (
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic [W-1:0] pin_in, // raw pins
    output logic [W-1:0] level_out // filtered level
);
    logic [W-1:0] s1_reg; // first stage, read only by s2
    logic [W-1:0] s2_reg; // second stage
    logic [W-1:0] s3_reg; // third stage
    logic [W-1:0] lvl_reg; // accepted level
    logic [W-1:0] lvl_next; // next accepted level

    // a bit changes only once stages two and three agree
    assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            lvl_reg <= RST_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end
    assign level_out = lvl_reg;
endmodule // pin_sync3
`default_nettype wire

// ### hw/servo_status_output_logic.sv
// status output logic of a servo drive: threshold compares and state flags
`timescale 1ns/1ps
`default_nettype none
module servo_status_output_logic
    import servo_status_pkg::*;
#(
    parameter int DW = 16, // width of speed, torque and position words
    parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS // clocks per control cycle
) (
    input wire logic core_clk, // system clock, 100 MHz
    input wire logic sys_rst, // async reset, active high
    input wire logic [1:0] ctrl_mode, // control mode code
    input wire logic signed [DW-1:0] speed_filt, // filtered motor speed
    input wire logic signed [DW-1:0] speed_fb, // speed feedback
    input wire logic signed [DW-1:0] speed_ref, // speed reference
    input wire logic signed [DW-1:0] torque_ref, // torque reference
    input wire logic signed [DW-1:0] pos_dev, // position deviation, pulses
    input wire logic [DW-1:0] rotation_threshold, // turning threshold
    input wire logic [DW-1:0] speed_track_window, // tracking window
    input wire logic [DW-1:0] speed_match_window, // match window
    input wire logic [DW-1:0] position_done_window, // completion window
    input wire logic [DW-1:0] proximity_window, // proximity window
    input wire logic [DW-1:0] torque_limit, // torque limit magnitude
    input wire logic [DW-1:0] torque_setpoint, // torque reach setpoint
    input wire logic [DW-1:0] speed_setpoint, // speed reach setpoint
    input wire logic drive_ready, // drive can accept servo-on
    input wire logic speed_limited, // speed limiter active
    input wire logic brake_release_req, // brake sequencer wants release
    input wire logic warn_present, // warning active
    input wire logic warn_reset, // warning reset request
    input wire logic fault_present, // fault active
    input wire logic fault_reset, // fault reset request
    input wire logic homing_complete, // homing sequence finished
    input wire logic db_relay_open, // dynamic brake relay open
    input wire logic compare_passed, // comparison point crossed
    input wire logic sto1_lost, // safe channel 1 supply lost, pin
    input wire logic sto2_lost, // safe channel 2 supply lost, pin
    input wire logic safe_torque_off, // safe torque off triggered
    output logic ready_flag, // ready to switch on
    output logic motor_turning_flag, // motor rotating
    output logic speed_track_flag, // speed tracking
    output logic speed_match_flag, // speed match
    output logic position_done_flag, // positioning done
    output logic proximity_flag, // proximity
    output logic torque_clamped_flag, // torque clamped
    output logic speed_clamped_flag, // speed clamped
    output logic brake_release_out, // brake released
    output logic alert_flag, // warning
    output logic fault_flag, // fault
    output logic homing_done_flag, // homing done
    output logic torque_reached_flag, // torque reached
    output logic speed_reached_flag, // speed reached
    output logic dyn_brake_out, // dynamic brake relay open
    output logic compare_pass_flag, // compare point passed
    output logic any_alert_flag, // warning or fault
    output logic external_monitor_out // safe torque off monitor
);
    localparam int CW = 16; // cycle counter width

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // magnitude of a sign-extended word
    function automatic logic [DW:0] mag(input logic signed [DW:0] v);
        mag = v[DW] ? -v : v;
    endfunction

    // sign extension to one extra bit
    function automatic logic signed [DW:0] sx(input logic signed [DW-1:0] v);
        sx = {v[DW-1], v};
    endfunction

    // threshold widened to magnitude width
    function automatic logic [DW:0] ux(input logic [DW-1:0] v);
        ux = {1'b0, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control cycle divider

    logic [CW-1:0] cnt_reg; // divider count
    logic [CW-1:0] cnt_next; // next divider count
    logic cyc_en_reg; // one-cycle control tick
    logic cnt_wrap; // divider at last count

    assign cnt_wrap = cnt_reg == CW'(CYCLE_CLKS - 1);
    assign cnt_next = cnt_wrap ? '0 : cnt_reg + CW'(1);

    // tick once per control cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            cyc_en_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            cyc_en_reg <= cnt_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // safe channel pins

    logic [1:0] sto_lvl; // filtered channel lost levels

    pin_sync3 #(.W(2), .RST_VAL(STO_LOST_RESET)) u_sto_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in({sto2_lost, sto1_lost}),
        .level_out(sto_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // comparisons

    logic [DW:0] spd_filt_mag; // abs filtered speed
    logic [DW:0] spd_err_mag; // abs feedback minus reference
    logic [DW:0] spd_fb_mag; // abs feedback
    logic [DW:0] trq_mag; // abs torque reference
    logic [DW:0] dev_mag; // abs position deviation
    logic pos_mode; // position control active
    logic spd_mode; // speed control active
    logic trq_mode; // torque control active
    logic warn_lat_reg; // warning not yet reset
    logic fault_lat_reg; // fault not yet reset
    logic warn_prev_reg; // warning level one clock ago
    logic fault_prev_reg; // fault level one clock ago
    logic warn_lat_next; // next warning latch
    logic fault_lat_next; // next fault latch
    logic [NUM_FLAGS-1:0] flags_next; // next status vector
    logic [NUM_FLAGS-1:0] flags_reg; // status vector

    assign spd_filt_mag = mag(sx(speed_filt));
    assign spd_err_mag = mag(sx(speed_fb) - sx(speed_ref));
    assign spd_fb_mag = mag(sx(speed_fb));
    assign trq_mag = mag(sx(torque_ref));
    assign dev_mag = mag(sx(pos_dev));
    assign pos_mode = ctrl_mode == MODE_POSITION;
    assign spd_mode = ctrl_mode == MODE_SPEED;
    assign trq_mode = ctrl_mode == MODE_TORQUE;

    // a reset clears a standing event until it rises again; a fresh rise beats the reset
    assign warn_lat_next = warn_present & ((warn_lat_reg & ~warn_reset) | ~warn_prev_reg);
    assign fault_lat_next = fault_present & ((fault_lat_reg & ~fault_reset) | ~fault_prev_reg);

    // warning and fault stay until reset or gone
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            warn_lat_reg <= 1'b0;
            fault_lat_reg <= 1'b0;
            warn_prev_reg <= 1'b0;
            fault_prev_reg <= 1'b0;
        end else begin
            warn_lat_reg <= warn_lat_next;
            fault_lat_reg <= fault_lat_next;
            warn_prev_reg <= warn_present;
            fault_prev_reg <= fault_present;
        end
    end

    assign flags_next[F_READY] = drive_ready;
    assign flags_next[F_TURN] = spd_filt_mag >= ux(rotation_threshold);
    assign flags_next[F_TRACK] = spd_err_mag <= ux(speed_track_window);
    assign flags_next[F_MATCH] = spd_mode & (spd_err_mag < ux(speed_match_window));
    assign flags_next[F_PDONE] = pos_mode & (dev_mag <= ux(position_done_window));
    assign flags_next[F_PROX] = pos_mode & (dev_mag <= ux(proximity_window));
    assign flags_next[F_TCLAMP] = trq_mag >= ux(torque_limit);
    assign flags_next[F_SCLAMP] = trq_mode & speed_limited;
    assign flags_next[F_BRAKE] = brake_release_req;
    assign flags_next[F_ALERT] = warn_lat_reg;
    assign flags_next[F_FAULT] = fault_lat_reg;
    assign flags_next[F_HOME] = pos_mode & homing_complete;
    assign flags_next[F_TREACH] = trq_mag >= ux(torque_setpoint);
    assign flags_next[F_SREACH] = spd_fb_mag >= ux(speed_setpoint);
    assign flags_next[F_DYNBRK] = db_relay_open;
    assign flags_next[F_CMP] = compare_passed;
    assign flags_next[F_ANY] = warn_lat_reg | fault_lat_reg;
    assign flags_next[F_EXTMON] = safe_torque_off & sto_lvl[0] & sto_lvl[1];

    ////////////////////////////////////////////////////////////////////////
    // status register

    // refresh the whole vector on each control tick
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_reg <= FLAGS_RESET;
        end else if (cyc_en_reg) begin
            flags_reg <= flags_next;
        end
    end

    assign ready_flag = flags_reg[F_READY];
    assign motor_turning_flag = flags_reg[F_TURN];
    assign speed_track_flag = flags_reg[F_TRACK];
    assign speed_match_flag = flags_reg[F_MATCH];
    assign position_done_flag = flags_reg[F_PDONE];
    assign proximity_flag = flags_reg[F_PROX];
    assign torque_clamped_flag = flags_reg[F_TCLAMP];
    assign speed_clamped_flag = flags_reg[F_SCLAMP];
    assign brake_release_out = flags_reg[F_BRAKE];
    assign alert_flag = flags_reg[F_ALERT];
    assign fault_flag = flags_reg[F_FAULT];
    assign homing_done_flag = flags_reg[F_HOME];
    assign torque_reached_flag = flags_reg[F_TREACH];
    assign speed_reached_flag = flags_reg[F_SREACH];
    assign dyn_brake_out = flags_reg[F_DYNBRK];
    assign compare_pass_flag = flags_reg[F_CMP];
    assign any_alert_flag = flags_reg[F_ANY];
    assign external_monitor_out = flags_reg[F_EXTMON];

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    localparam int CYCLE_MAX = CYCLE_CLKS + 3; // limit on clocks from a cleared fault to a low flag; the worst case is CYCLE_CLKS + 1

    // one control tick
    sequence s_tick;
        cyc_en_reg;
    endsequence

    // a tick in speed mode with a small error
    sequence s_match_tick;
        cyc_en_reg && spd_mode && (spd_err_mag < ux(speed_match_window));
    endsequence

    // outputs hold between ticks
    property p_hold;
        !cyc_en_reg |=> $stable(flags_reg);
    endproperty

    a_cycle_hold: assert property (p_hold) else $error("status changed between ticks");
    a_tick_spacing: assert property (s_tick |=> !cyc_en_reg [*2]) else $error("ticks too close");
    a_turn_update: assert property (s_tick |=> motor_turning_flag == $past(spd_filt_mag >= ux(rotation_threshold)))
        else $error("turning flag wrong");
    a_track_update: assert property (s_tick |=> speed_track_flag == $past(spd_err_mag <= ux(speed_track_window)))
        else $error("tracking flag wrong");
    a_match_set: assert property (s_match_tick |=> speed_match_flag) else $error("match flag not set");
    a_pos_only: assert property ((position_done_flag || proximity_flag || homing_done_flag) |-> $past(pos_mode, 1)
        || $past(!cyc_en_reg)) else $error("position flag outside position mode");
    a_prox_sep: assert property (s_tick ##0 (pos_mode && dev_mag > ux(position_done_window)
        && dev_mag <= ux(proximity_window)) |=> proximity_flag && !position_done_flag)
        else $error("proximity window wrong");
    a_tclamp_set: assert property (s_tick ##0 (trq_mag >= ux(torque_limit)) |=> torque_clamped_flag)
        else $error("torque clamp flag missing");
    a_sclamp_mode: assert property (s_tick ##0 !trq_mode |=> !speed_clamped_flag)
        else $error("speed clamp outside torque mode");
    a_brake_follow: assert property (s_tick |=> brake_release_out == $past(brake_release_req))
        else $error("brake output wrong");
    a_alert_clear: assert property (s_tick ##0 !warn_lat_reg |=> !alert_flag) else $error("alert stuck");
    a_fault_clear: assert property (!fault_present |=> ##[0:CYCLE_MAX] !fault_flag)
        else $error("fault flag stuck");
    a_treach_set: assert property (s_tick |=> torque_reached_flag == $past(trq_mag >= ux(torque_setpoint)))
        else $error("torque reach wrong");
    a_sreach_set: assert property (s_tick |=> speed_reached_flag == $past(spd_fb_mag >= ux(speed_setpoint)))
        else $error("speed reach wrong");
    a_dynbrk_follow: assert property (s_tick |=> dyn_brake_out == $past(db_relay_open))
        else $error("dynamic brake wrong");
    a_any_alert: assert property (any_alert_flag == (alert_flag || fault_flag)) else $error("any alert mismatch");
    a_extmon_both: assert property (s_tick ##0 !(sto_lvl[0] && sto_lvl[1]) |=> !external_monitor_out)
        else $error("monitor with one channel");
    a_ready_follow: assert property (s_tick |=> ready_flag == $past(drive_ready)) else $error("ready wrong");
    a_cmp_follow: assert property (s_tick |=> compare_pass_flag == $past(compare_passed)) else $error("compare wrong");
    a_home_set: assert property (s_tick ##0 (pos_mode && homing_complete) |=> homing_done_flag)
        else $error("homing flag missing");
endmodule // servo_status_output_logic
`default_nettype wire

// ### hw/servo_status_pkg.sv
// constants shared by the servo status output logic
package servo_status_pkg;
    // clock and control cycle timing
    localparam int CLK_PERIOD_NS = 10; // core_clk period
    localparam int CTRL_CYCLE_NS = 1000; // control cycle length
    localparam int CTRL_CYCLE_CLKS = (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // clocks per cycle
    // control mode codes
    typedef enum logic [1:0] {
        MODE_POSITION = 2'h0, // position control
        MODE_SPEED = 2'h1, // speed control
        MODE_TORQUE = 2'h2 // torque control
    } ctrl_mode_t;
    // field positions inside the status vector
    localparam int F_READY = 0; // ready to switch on
    localparam int F_TURN = 1; // motor rotating
    localparam int F_TRACK = 2; // speed tracking
    localparam int F_MATCH = 3; // speed match
    localparam int F_PDONE = 4; // positioning done
    localparam int F_PROX = 5; // proximity
    localparam int F_TCLAMP = 6; // torque clamped
    localparam int F_SCLAMP = 7; // speed clamped
    localparam int F_BRAKE = 8; // brake released
    localparam int F_ALERT = 9; // warning
    localparam int F_FAULT = 10; // fault
    localparam int F_HOME = 11; // homing done
    localparam int F_TREACH = 12; // torque reached
    localparam int F_SREACH = 13; // speed reached
    localparam int F_DYNBRK = 14; // dynamic brake relay open
    localparam int F_CMP = 15; // compare point passed
    localparam int F_ANY = 16; // warning or fault
    localparam int F_EXTMON = 17; // safe torque off monitor
    localparam int NUM_FLAGS = 18; // width of status vector
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 18'h00000; // all inactive after reset
    localparam logic [1:0] STO_LOST_RESET = 2'h0; // sync state after reset
endpackage

// ### verification/host_status_reader.sv
// host-side model that reads the drive's status outputs every clock
`timescale 1ns/1ps
`default_nettype none
module host_status_reader
    import servo_status_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic [NUM_FLAGS-1:0] flags_in, // drive outputs, indexed by field position
    output var logic [NUM_FLAGS-1:0] status_out // last value the host read
);
    ////////////////////////////////////////////////////////////////////////
    // the host latches all outputs on each rising edge; it has no reset of its own,
    // so a drive that misbehaves in reset is seen as it is
    always_ff @(posedge core_clk) begin
        status_out <= flags_in;
    end
endmodule // host_status_reader
`default_nettype wire

// ### verification/servo_status_output_logic_tb.sv
// self-checking bench for the servo status output logic
`timescale 1ns/1ps
`default_nettype none
module servo_status_output_logic_tb
    import servo_status_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    localparam int CYC = 4; // shortened control cycle
    localparam int SETTLE = 2 * CYC + 8; // clocks for an input to reach the host
    logic core_clk = 1'b0; // system clock
    logic sys_rst = 1'b1; // async reset
    logic [1:0] ctrl_mode = 2'h3; // no mode selected
    logic signed [15:0] speed_filt = 16'sh0000, speed_fb = 16'sh0000, speed_ref = 16'sh01F4; // speeds
    logic signed [15:0] torque_ref = 16'sh0000, pos_dev = 16'sh03E8; // torque and deviation
    logic [15:0] rot_thr = 16'h0064, track_win = 16'h0064, match_win = 16'h0032; // speed thresholds
    logic [15:0] done_win = 16'h000A, prox_win = 16'h0032; // position windows
    logic [15:0] tq_lim = 16'h0320, tq_set = 16'h0190, sp_set = 16'h03E8; // torque and speed setpoints
    logic drive_ready = 1'b0, speed_limited = 1'b0, brake_release_req = 1'b0, warn_present = 1'b0; // states
    logic warn_reset = 1'b0, fault_present = 1'b0, fault_reset = 1'b0, homing_complete = 1'b0; // states
    logic db_relay_open = 1'b0, compare_passed = 1'b0, safe_torque_off = 1'b0; // states
    logic sto1_lost = 1'b0, sto2_lost = 1'b0; // safe channel pins
    logic ready_flag, motor_turning_flag, speed_track_flag, speed_match_flag, position_done_flag; // outputs
    logic proximity_flag, torque_clamped_flag, speed_clamped_flag, brake_release_out, alert_flag; // outputs
    logic fault_flag, homing_done_flag, torque_reached_flag, speed_reached_flag, dyn_brake_out; // outputs
    logic compare_pass_flag, any_alert_flag, external_monitor_out; // outputs
    logic [NUM_FLAGS-1:0] host_status; // what the host last read
    int failures = 0; // mismatches
    int cmp_count = 0; // comparisons made

    ////////////////////////////////////////////////////////////////////////
    // clock
    always #5 core_clk = ~core_clk;

    // device under test, control cycle shortened for simulation
    servo_status_output_logic #(.DW(16), .CYCLE_CLKS(CYC)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .ctrl_mode(ctrl_mode), .speed_filt(speed_filt),
        .speed_fb(speed_fb), .speed_ref(speed_ref), .torque_ref(torque_ref), .pos_dev(pos_dev),
        .rotation_threshold(rot_thr), .speed_track_window(track_win), .speed_match_window(match_win),
        .position_done_window(done_win), .proximity_window(prox_win), .torque_limit(tq_lim),
        .torque_setpoint(tq_set), .speed_setpoint(sp_set), .drive_ready(drive_ready),
        .speed_limited(speed_limited), .brake_release_req(brake_release_req), .warn_present(warn_present),
        .warn_reset(warn_reset), .fault_present(fault_present), .fault_reset(fault_reset),
        .homing_complete(homing_complete), .db_relay_open(db_relay_open), .compare_passed(compare_passed),
        .sto1_lost(sto1_lost), .sto2_lost(sto2_lost), .safe_torque_off(safe_torque_off),
        .ready_flag(ready_flag), .motor_turning_flag(motor_turning_flag), .speed_track_flag(speed_track_flag),
        .speed_match_flag(speed_match_flag), .position_done_flag(position_done_flag),
        .proximity_flag(proximity_flag), .torque_clamped_flag(torque_clamped_flag),
        .speed_clamped_flag(speed_clamped_flag), .brake_release_out(brake_release_out),
        .alert_flag(alert_flag), .fault_flag(fault_flag), .homing_done_flag(homing_done_flag),
        .torque_reached_flag(torque_reached_flag), .speed_reached_flag(speed_reached_flag),
        .dyn_brake_out(dyn_brake_out), .compare_pass_flag(compare_pass_flag),
        .any_alert_flag(any_alert_flag), .external_monitor_out(external_monitor_out));

    // host model, outputs packed by field position
    host_status_reader host (.core_clk(core_clk), .status_out(host_status),
        .flags_in({external_monitor_out, any_alert_flag, compare_pass_flag, dyn_brake_out, speed_reached_flag,
            torque_reached_flag, homing_done_flag, fault_flag, alert_flag, brake_release_out, speed_clamped_flag,
            torque_clamped_flag, proximity_flag, position_done_flag, speed_match_flag, speed_track_flag,
            motor_turning_flag, ready_flag}));

    ////////////////////////////////////////////////////////////////////////
    // one-hot mask of a field
    function automatic logic [NUM_FLAGS-1:0] fb(input int i);
        return NUM_FLAGS'(1'h1) << i;
    endfunction

    // compare and count
    task automatic check(input string what, input logic [NUM_FLAGS-1:0] seen, input logic [NUM_FLAGS-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // wait until a change has passed a tick and reached the host
    task automatic settle();
        repeat (SETTLE) @(posedge core_clk);
        #1;
    endtask

    // print counts and the verdict, then stop
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // outputs stay low in reset and until the first tick, although inputs are active
    task automatic t_reset();
        drive_ready <= 1'b1;
        brake_release_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1 check("status in reset", host_status, FLAGS_RESET);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1 check("status after release", host_status, FLAGS_RESET);
        settle();
        check("status first cycle", host_status, fb(F_READY) | fb(F_BRAKE));
        drive_ready <= 1'b0;
        brake_release_req <= 1'b0;
        settle();
        check("status cleared", host_status, FLAGS_RESET);
    endtask

    // turning and speed reached at and just below their thresholds
    task automatic t_turn();
        speed_filt <= -16'sh0064;
        speed_fb <= 16'sh03E8;
        settle();
        check("turning at threshold", host_status, fb(F_TURN) | fb(F_SREACH));
        speed_filt <= -16'sh0063;
        speed_fb <= 16'sh03E7;
        settle();
        check("turning below threshold", host_status, FLAGS_RESET);
        speed_filt <= 16'sh0000;
    endtask

    // tracking window inclusive, match window strict, match only in speed mode
    task automatic t_speed();
        ctrl_mode <= MODE_SPEED;
        speed_fb <= 16'sh0226;
        settle();
        check("error at match window", host_status, fb(F_TRACK));
        speed_fb <= 16'sh0225;
        settle();
        check("error inside match", host_status, fb(F_TRACK) | fb(F_MATCH));
        speed_fb <= 16'sh0190;
        settle();
        check("error at track window", host_status, fb(F_TRACK));
        speed_fb <= 16'sh018F;
        settle();
        check("error past track", host_status, FLAGS_RESET);
        ctrl_mode <= MODE_POSITION;
        speed_fb <= 16'sh0225;
        settle();
        check("match outside speed mode", host_status, fb(F_TRACK));
        speed_fb <= 16'sh0000;
    endtask

    // completion and proximity windows in position mode only
    task automatic t_pos();
        ctrl_mode <= MODE_POSITION;
        pos_dev <= -16'sh000A;
        settle();
        check("deviation at done", host_status, fb(F_PDONE) | fb(F_PROX));
        pos_dev <= 16'sh000B;
        settle();
        check("deviation past done", host_status, fb(F_PROX));
        pos_dev <= 16'sh0033;
        settle();
        check("deviation past proximity", host_status, FLAGS_RESET);
        ctrl_mode <= MODE_SPEED;
        pos_dev <= 16'sh0000;
        settle();
        check("deviation in speed mode", host_status, FLAGS_RESET);
        pos_dev <= 16'sh03E8;
    endtask

    // torque clamp, torque reached and speed clamp
    task automatic t_torque();
        ctrl_mode <= MODE_TORQUE;
        torque_ref <= -16'sh0320;
        speed_limited <= 1'b1;
        settle();
        check("torque at limit", host_status, fb(F_TCLAMP) | fb(F_TREACH) | fb(F_SCLAMP));
        torque_ref <= 16'sh031F;
        speed_limited <= 1'b0;
        settle();
        check("torque below limit", host_status, fb(F_TREACH));
        ctrl_mode <= MODE_SPEED;
        torque_ref <= 16'sh018F;
        speed_limited <= 1'b1;
        settle();
        check("torque below setpoint", host_status, FLAGS_RESET);
        speed_limited <= 1'b0;
        torque_ref <= 16'sh0000;
    endtask

    // plain state follows, homing gated by position mode
    task automatic t_follow();
        ctrl_mode <= MODE_POSITION;
        {db_relay_open, compare_passed, homing_complete} <= 3'h7;
        settle();
        check("states set", host_status, fb(F_DYNBRK) | fb(F_CMP) | fb(F_HOME));
        ctrl_mode <= MODE_SPEED;
        settle();
        check("homing outside position", host_status, fb(F_DYNBRK) | fb(F_CMP));
        {db_relay_open, compare_passed, homing_complete} <= 3'h0;
        settle();
        check("states cleared", host_status, FLAGS_RESET);
    endtask

    // warning, fault and the combined alert
    task automatic t_alert();
        warn_present <= 1'b1;
        settle();
        check("warning only", host_status, fb(F_ALERT) | fb(F_ANY));
        warn_reset <= 1'b1;
        @(posedge core_clk);
        warn_reset <= 1'b0;
        settle();
        check("warning reset while present", host_status, FLAGS_RESET);
        fault_present <= 1'b1;
        warn_present <= 1'b0;
        settle();
        check("fault only", host_status, fb(F_FAULT) | fb(F_ANY));
        fault_present <= 1'b0;
        fault_reset <= 1'b1;
        @(posedge core_clk);
        fault_reset <= 1'b0;
        settle();
        check("no alert", host_status, FLAGS_RESET);
    endtask

    // monitor output needs the trigger and both channels lost
    task automatic t_sto();
        safe_torque_off <= 1'b1;
        sto1_lost <= 1'b1;
        settle();
        check("one channel lost", host_status, FLAGS_RESET);
        sto2_lost <= 1'b1;
        settle();
        check("both channels lost", host_status, fb(F_EXTMON));
        safe_torque_off <= 1'b0;
        settle();
        check("trigger removed", host_status, FLAGS_RESET);
        {sto1_lost, sto2_lost} <= 2'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        @(posedge core_clk);
        t_reset();
        t_turn();
        t_speed();
        t_pos();
        t_torque();
        t_follow();
        t_alert();
        t_sto();
        wrap_up();
    end

    // watchdog, well beyond the few hundred clocks the sequence needs
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        wrap_up();
    end
endmodule // servo_status_output_logic_tb
`default_nettype wire
